//--- hw/arc_codec.sv
// Address-resolution PDU builder/parser and IPv4 packet framer
`timescale 1ns/1ps
`default_nettype none
module arc_codec import arc_pkg::*; #(
  parameter int RETRY = RETRY_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [2:0]  req_kind_in,
  input  wire logic [31:0] req_ip_in,
  input  wire logic [47:0] req_hw_in,
  output logic             pending_out,
  input  wire logic        pkt_valid_in,
  output logic             pkt_ready_out,
  input  wire logic [7:0]  pkt_data_in,
  input  wire logic        pkt_last_in,
  input  wire logic        pkt_compress_in,
  input  wire logic [1:0]  pkt_kind_in,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic [7:0]       tx_data_out,
  output logic             tx_last_out,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_last_in,
  output logic             ack_valid_out,
  output logic [7:0]       ack_type_out,
  output logic [31:0]      ack_ip_out,
  output logic [47:0]      ack_hw_out,
  output logic [5:0]       ack_lcid_out,
  output logic             ack_found_out,
  output logic             rx_error_out
);
  typedef struct packed {
    arc_state_e          state;
    logic [87:0]         msg;
    logic [3:0]          left;
    logic                pend;
    logic [7:0]          ptype;
    logic [31:0]         pip;
    logic [47:0]         phw;
    logic [TIMER_W-1:0]  timer;
    logic [5:0]          seq;
    logic                comp;
    logic                hdr;
    logic                drop;
    logic [1:0]          pkind;
    logic [95:0]         rbuf;
    logic [3:0]          rcnt;
    logic                ack_v;
    logic [7:0]          ack_type;
    logic [31:0]         ack_ip;
    logic [47:0]         ack_hw;
    logic [5:0]          ack_lcid;
    logic                found;
    logic                rx_err;
  } arc_top_s;

  arc_top_s    st;
  arc_top_s    next_st;
  logic        req_ok;
  logic [7:0]  req_type;
  logic        resend_due;
  logic        req_take;

  arc_stream_if #(.W(OCTET_W + 1)) fill_if ();
  arc_stream_if #(.W(OCTET_W + 1)) drain_if ();

  arc_pair_buf #(.W(OCTET_W + 1), .DEPTH(2)) u_buf (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .fill       (fill_if.snk),
    .drain      (drain_if.src)
  );

  assign tx_valid_out   = drain_if.valid;
  assign tx_data_out    = drain_if.data[OCTET_W-1:0];
  assign tx_last_out    = drain_if.data[OCTET_W];
  assign drain_if.ready = tx_ready_in;

  // Only the five outgoing codes can ever be produced
  always_comb begin
    req_ok = 1'b1;
    case (req_kind_in)
      REQ_BIND:    req_type = TYPE_BIND_REQ;
      REQ_UNBIND:  req_type = TYPE_UNBIND_REQ;
      REQ_RESOLVE: req_type = TYPE_RESOLVE_REQ;
      REQ_JOIN:    req_type = TYPE_JOIN_REQ;
      REQ_LEAVE:   req_type = TYPE_LEAVE_REQ;
      default: begin
        req_type = TYPE_BIND_REQ;
        req_ok   = 1'b0;
      end
    endcase
  end

  function automatic logic addr_pair(input logic [7:0] t);
    return (t == TYPE_BIND_REQ) || (t == TYPE_UNBIND_REQ);
  endfunction

  assign resend_due    = st.pend && (st.timer >= TIMER_W'(RETRY - 1));
  assign req_ready_out = (st.state == ST_IDLE) && !resend_due && !st.pend && req_ok;
  assign req_take      = req_valid_in && req_ready_out;
  assign pending_out   = st.pend;
  assign ack_valid_out = st.ack_v;
  assign ack_type_out  = st.ack_type;
  assign ack_ip_out    = st.ack_ip;
  assign ack_hw_out    = st.ack_hw;
  assign ack_lcid_out  = st.ack_lcid;
  assign ack_found_out = st.found;
  assign rx_error_out  = st.rx_err;

  always_comb begin
    logic [95:0] nb;
    logic [3:0]  n;
    logic [7:0]  t;
    logic [31:0] ip;
    logic [47:0] hw;
    logic [5:0]  lcid;
    logic        ok;
    logic        fnd;
    nb   = {st.rbuf[87:0], rx_data_in};
    n    = st.rcnt + 4'h1;
    t    = 8'hff;
    ip   = '0;
    hw   = '0;
    lcid = '0;
    ok   = 1'b0;
    fnd  = 1'b0;
    next_st        = st;
    next_st.ack_v  = 1'b0;
    next_st.rx_err = 1'b0;
    fill_if.valid  = 1'b0;
    fill_if.data   = '0;
    pkt_ready_out  = 1'b0;
    if (st.pend && st.state != ST_MSG && !resend_due) begin
      next_st.timer = st.timer + 1'b1;
    end
    case (st.state)
      ST_IDLE: begin
        if (resend_due) begin
          next_st.msg   = {st.ptype, st.pip, addr_pair(st.ptype) ? st.phw : 48'h0};
          next_st.left  = addr_pair(st.ptype) ? LEN_ADDR_MSG : LEN_IP_MSG;
          next_st.timer = '0;
          next_st.state = ST_MSG;
        end else if (req_take) begin
          next_st.ptype = req_type;
          next_st.pip   = req_ip_in;
          next_st.phw   = req_hw_in;
          next_st.pend  = 1'b1;
          next_st.timer = '0;
          next_st.msg   = {req_type, req_ip_in, addr_pair(req_type) ? req_hw_in : 48'h0};
          next_st.left  = addr_pair(req_type) ? LEN_ADDR_MSG : LEN_IP_MSG;
          next_st.state = ST_MSG;
        end else if (pkt_valid_in) begin
          next_st.comp  = pkt_compress_in;
          next_st.hdr   = pkt_compress_in && (pkt_kind_in != KIND_ERROR);
          next_st.drop  = pkt_compress_in && (pkt_kind_in == KIND_ERROR);
          next_st.pkind = pkt_kind_in;
          next_st.state = ST_PKT;
        end
      end
      ST_MSG: begin
        fill_if.valid = 1'b1;
        fill_if.data  = {st.left == 4'h1, st.msg[87:80]};
        if (fill_if.ready) begin
          next_st.msg  = {st.msg[79:0], 8'h00};
          next_st.left = st.left - 4'h1;
          if (st.left == 4'h1) begin
            next_st.state = ST_IDLE;
          end
        end
      end
      ST_PKT: begin
        if (st.hdr) begin
          fill_if.valid = 1'b1;
          fill_if.data  = {1'b0, st.pkind, st.seq};
          if (fill_if.ready) begin
            next_st.hdr = 1'b0;
            next_st.seq = st.seq + 6'h01;
          end
        end else begin
          pkt_ready_out = st.drop || fill_if.ready;
          fill_if.valid = !st.drop && pkt_valid_in;
          fill_if.data  = {pkt_last_in, pkt_data_in};
          if (pkt_valid_in && pkt_ready_out && pkt_last_in) begin
            next_st.drop  = 1'b0;
            next_st.state = ST_IDLE;
          end
        end
      end
      default: next_st.state = ST_IDLE;
    endcase
    if (rx_valid_in) begin
      if (!rx_last_in) begin
        next_st.rbuf = nb;
        next_st.rcnt = (st.rcnt == 4'hf) ? st.rcnt : n;
      end else begin
        next_st.rbuf = '0;
        next_st.rcnt = '0;
        case (n)
          LEN_IP_MSG: begin
            t  = nb[39:32];
            ip = nb[31:0];
            ok = (t == TYPE_LEAVE_ACK);
          end
          LEN_JOIN_ACK: begin
            t    = nb[47:40];
            ip   = nb[39:8];
            lcid = nb[5:0];
            ok   = (t == TYPE_JOIN_ACK);
          end
          LEN_ADDR_MSG: begin
            t  = nb[87:80];
            ip = nb[79:48];
            hw = nb[47:0];
            ok = (t == TYPE_BIND_ACK) || (t == TYPE_UNBIND_ACK);
          end
          LEN_REPLY: begin
            t   = nb[95:88];
            ip  = nb[87:56];
            fnd = (nb[7:0] == STATUS_FOUND);
            hw  = fnd ? nb[55:8] : 48'h0;
            ok  = (t == TYPE_RESOLVE_REPLY);
          end
          default: ok = 1'b0;
        endcase
        if (t > TYPE_MAX) begin
          ok = 1'b0;
        end
        next_st.rx_err   = !ok;
        next_st.ack_v    = ok;
        next_st.ack_type = ok ? t : st.ack_type;
        next_st.ack_ip   = ok ? ip : st.ack_ip;
        next_st.ack_hw   = ok ? hw : st.ack_hw;
        next_st.ack_lcid = ok ? lcid : st.ack_lcid;
        next_st.found    = ok ? fnd : st.found;
        if (ok && st.pend && t == st.ptype + 8'h01 && ip == st.pip &&
            (!addr_pair(st.ptype) || hw == st.phw)) begin
          next_st.pend = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  chk_type_defined: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    req_take |=> st.msg[87:80] <= TYPE_MAX && st.msg[87:80] != 8'h06 && st.msg[87:80] != 8'h07)
    else $error("generated message type not defined");
  chk_bind_format: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    req_take && req_kind_in == REQ_BIND |=> st.left == 4'hb && st.msg[87:80] == 8'h00)
    else $error("bind request malformed");
  chk_unbind_format: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    req_take && req_kind_in == REQ_UNBIND |=> st.left == 4'hb && st.msg[87:80] == 8'h02)
    else $error("unbind request malformed");
  chk_resolve_short: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    req_take && req_kind_in == REQ_RESOLVE |=> st.left == 4'h5 && st.msg[87:80] == 8'h04)
    else $error("resolve request malformed");
  chk_join_short: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    req_take && req_kind_in == REQ_JOIN |=> st.left == 4'h5 && st.msg[87:80] == 8'h08)
    else $error("join request malformed");
  chk_leave_short: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    req_take && req_kind_in == REQ_LEAVE |=> st.left == 4'h5 && st.msg[87:80] == 8'h0a)
    else $error("leave request malformed");
  chk_ip_order: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    req_take |=> st.msg[79:48] == $past(req_ip_in) && st.state == ST_MSG)
    else $error("address not behind type octet");
  chk_miss_hidden: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    ack_valid_out && ack_type_out == 8'h05 && !ack_found_out |-> ack_hw_out == 48'h0)
    else $error("unresolved reply exposes hardware address");
  chk_bare_packet: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    st.state == ST_PKT && !st.comp |-> !st.hdr && fill_if.data == {pkt_last_in, pkt_data_in})
    else $error("header on uncompressed packet");
  chk_one_header: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    st.hdr && fill_if.ready |=> !st.hdr && st.seq == $past(st.seq) + 6'h01)
    else $error("header octet not single");
  chk_no_error_kind: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    st.hdr |-> st.pkind != 2'h3)
    else $error("error kind transmitted");
  chk_retry_due: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    st.state == ST_IDLE && resend_due |=> st.state == ST_MSG && st.timer == '0)
    else $error("unanswered request not resent");
endmodule : arc_codec
`default_nettype wire

//--- hw/arc_pkg.sv
// Constants and types of the address-resolution PDU codec
package arc_pkg;
  localparam logic [7:0] TYPE_BIND_REQ      = 8'h00;
  localparam logic [7:0] TYPE_BIND_ACK      = 8'h01;
  localparam logic [7:0] TYPE_UNBIND_REQ    = 8'h02;
  localparam logic [7:0] TYPE_UNBIND_ACK    = 8'h03;
  localparam logic [7:0] TYPE_RESOLVE_REQ   = 8'h04;
  localparam logic [7:0] TYPE_RESOLVE_REPLY = 8'h05;
  localparam logic [7:0] TYPE_JOIN_REQ      = 8'h08;
  localparam logic [7:0] TYPE_JOIN_ACK      = 8'h09;
  localparam logic [7:0] TYPE_LEAVE_REQ     = 8'h0a;
  localparam logic [7:0] TYPE_LEAVE_ACK     = 8'h0b;
  localparam logic [7:0] TYPE_MAX           = 8'h0b;
  localparam logic [3:0] LEN_ADDR_MSG       = 4'hb;
  localparam logic [3:0] LEN_IP_MSG         = 4'h5;
  localparam logic [3:0] LEN_JOIN_ACK       = 4'h6;
  localparam logic [3:0] LEN_REPLY          = 4'hc;
  localparam logic [7:0] STATUS_FOUND       = 8'h00;
  localparam logic [1:0] KIND_ERROR         = 2'h3;
  localparam int         OCTET_W            = 8;
  localparam int         RETRY_TIME_NS      = 1000000000;
  localparam int         CLK_PERIOD_NS      = 100;
  localparam int         RETRY_CYCLES       = RETRY_TIME_NS / CLK_PERIOD_NS;
  localparam int         TIMER_W            = 24;

  typedef enum logic [2:0] {
    REQ_BIND    = 3'h0,
    REQ_UNBIND  = 3'h1,
    REQ_RESOLVE = 3'h2,
    REQ_JOIN    = 3'h3,
    REQ_LEAVE   = 3'h4
  } arc_req_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MSG  = 2'b01,
    ST_PKT  = 2'b10
  } arc_state_e;
endpackage : arc_pkg

//--- hw/arc_stream_if.sv
// Valid/ready octet stream between the codec and its buffer
`timescale 1ns/1ps
`default_nettype none
interface arc_stream_if #(parameter int W = 9) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : arc_stream_if
`default_nettype wire

//--- hw/arc_pair_buf.sv
// Small FIFO that decouples the framer from a stalling receiver
`timescale 1ns/1ps
`default_nettype none
module arc_pair_buf #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  input  wire logic   clk_sys_in,
  input  wire logic   reset_in,
  arc_stream_if.snk   fill,
  arc_stream_if.src   drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } arc_buf_s;

  arc_buf_s st;
  arc_buf_s next_st;
  logic     push;
  logic     pop;

  assign fill.ready  = (st.cnt != (AW+1)'(DEPTH));
  assign drain.valid = (st.cnt != '0);
  assign drain.data  = st.mem[st.rp];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = fill.data;
      next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : arc_pair_buf
`default_nettype wire

//--- tb/arc_base_model.sv
// Behavioural coordinator node that answers address-resolution requests
`timescale 1ns/1ps
`default_nettype none
module arc_base_model (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_last_in,
  input  wire logic       slow_in,
  input  wire logic       reply_en_in,
  input  wire logic       bad_in,
  input  wire logic [7:0] status_in,
  input  wire logic [5:0] lcid_in,
  output logic            tx_ready_out,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_last_out
);
  logic [7:0]  m[$];
  logic [7:0]  r[$];
  logic [47:0] hw;
  logic [1:0]  cnt;
  logic [7:0]  d;

  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt <= 2'h0;
      tx_ready_out <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_last_out <= 1'b0;
      rx_data_out <= 8'h00;
      m.delete();
      r.delete();
    end else begin
      cnt <= cnt + 2'h1;
      // Slow mode accepts one octet in four
      tx_ready_out <= !slow_in || cnt == 2'h0;
      if (tx_valid_in && tx_ready_out) begin
        m.push_back(tx_data_in);
        if (tx_last_in) begin
          if (reply_en_in && (m[0] == 8'h00 || m[0] == 8'h02 || m[0] == 8'h04 ||
              m[0] == 8'h08 || m[0] == 8'h0a)) begin
            if (m.size() == 11) hw = {m[5], m[6], m[7], m[8], m[9], m[10]};
            r.push_back(m[0] + 8'h01);
            for (int i = 1; i < 5; i++) r.push_back(m[i]);
            if (m[0] < 8'h04) for (int i = 5; i < 11; i++) r.push_back(m[i]);
            if (m[0] == 8'h04) begin
              // Miss answers with garbage hardware address
              for (int i = 40; i >= 0; i -= 8) r.push_back(status_in == 8'h00 ? hw[i+:8] : ~hw[i+:8]);
              r.push_back(status_in);
            end
            if (m[0] == 8'h08) r.push_back({2'b00, lcid_in});
            if (bad_in) d = r.pop_back();
          end
          m.delete();
        end
      end
      if (r.size() > 0) begin
        d = r.pop_front();
        rx_valid_out <= 1'b1;
        rx_data_out <= d;
        rx_last_out <= r.size() == 0;
      end else begin
        rx_valid_out <= 1'b0;
        rx_last_out <= 1'b0;
        rx_data_out <= ~rx_data_out;
      end
    end
  end
endmodule : arc_base_model
`default_nettype wire

//--- tb/ipv4_addr_resolution_pdu_codec_tb.sv
// Self-checking bench for the address-resolution codec
`timescale 1ns/1ps
`default_nettype none
module ipv4_addr_resolution_pdu_codec_tb;
  import arc_pkg::*;
  logic        clk_sys_in = 0, reset_in = 1, req_valid = 0, pkt_valid = 0, pkt_last = 0;
  logic        pkt_comp = 0, slow = 0, reply_en = 1, bad = 0;
  logic [2:0]  req_kind = 0;
  logic [31:0] req_ip = 0, ip;
  logic [47:0] req_hw = 0, hw, last_hw, tmp;
  logic [7:0]  pkt_data = 0, status = 0, rnd = 8'h51;
  logic [1:0]  pkt_kind = 0;
  logic [5:0]  lcid = 6'h2a, seq = 0;
  wire logic   req_ready, pending, pkt_ready, tx_valid, tx_ready, tx_last, rx_valid, rx_last;
  wire logic   ack_valid, ack_found, rx_error;
  wire logic [7:0]  tx_data, rx_data, ack_type;
  wire logic [31:0] ack_ip;
  wire logic [47:0] ack_hw;
  wire logic [5:0]  ack_lcid;
  int          err_total = 0, cmp_count = 0, cyc = 0, errp = 0, ackp = 0;
  logic [8:0]  txq[$];

  arc_codec #(.RETRY(50)) uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_kind_in(req_kind),
    .req_ip_in(req_ip), .req_hw_in(req_hw), .pending_out(pending), .pkt_valid_in(pkt_valid),
    .pkt_ready_out(pkt_ready), .pkt_data_in(pkt_data), .pkt_last_in(pkt_last),
    .pkt_compress_in(pkt_comp), .pkt_kind_in(pkt_kind), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .tx_data_out(tx_data), .tx_last_out(tx_last),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_last_in(rx_last),
    .ack_valid_out(ack_valid), .ack_type_out(ack_type), .ack_ip_out(ack_ip),
    .ack_hw_out(ack_hw), .ack_lcid_out(ack_lcid), .ack_found_out(ack_found),
    .rx_error_out(rx_error));
  arc_base_model peer (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_last_in(tx_last), .slow_in(slow), .reply_en_in(reply_en),
    .bad_in(bad), .status_in(status), .lcid_in(lcid), .tx_ready_out(tx_ready),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_last_out(rx_last));

  always #50 clk_sys_in = ~clk_sys_in;

  always @(posedge clk_sys_in) begin
    cyc++;
    if (tx_valid && tx_ready) txq.push_back({tx_last, tx_data});
    if (rx_error === 1'b1) errp++;
    if (ack_valid === 1'b1) ackp++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  function automatic logic [7:0] nx(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nx

  task automatic rand48(output logic [47:0] v);
    v = 48'h0;
    repeat (6) begin
      rnd = nx(rnd);
      v = {v[39:0], rnd};
    end
  endtask : rand48

  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (e !== g) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [7:0] code(logic [2:0] k);
    case (k)
      3'h0: return TYPE_BIND_REQ;
      3'h1: return TYPE_UNBIND_REQ;
      3'h2: return TYPE_RESOLVE_REQ;
      3'h3: return TYPE_JOIN_REQ;
      default: return TYPE_LEAVE_REQ;
    endcase
  endfunction : code

  task automatic chk_msg(logic [2:0] k, logic [31:0] a, logic [47:0] h);
    int n;
    n = k < 2 ? 11 : 5;
    for (int i = 0; i < n; i++)
      chk("tx octet", {i == n - 1, i == 0 ? code(k) : i < 5 ? a[8*(4-i)+:8] : h[8*(10-i)+:8]},
          txq.size() > 0 ? txq.pop_front() : 9'bx);
  endtask : chk_msg

  task automatic go_req(logic [2:0] k);
    req_kind <= k;
    req_ip <= ip;
    req_hw <= hw;
    req_valid <= 1'b1;
    @(posedge clk_sys_in);
    while (req_ready !== 1'b1) @(posedge clk_sys_in);
    req_valid <= 1'b0;
    @(posedge clk_sys_in);
    while (pending !== 1'b0) @(posedge clk_sys_in);
  endtask : go_req

  task automatic send_pkt(logic c, logic [1:0] kd, int n);
    logic [8:0] e[$];
    if (c && kd != KIND_ERROR) begin
      e.push_back({1'b0, kd, seq});
      seq = seq + 6'h01;
    end
    pkt_comp <= c;
    pkt_kind <= kd;
    for (int i = 0; i < n; i++) begin
      rnd = nx(rnd);
      pkt_data <= rnd;
      pkt_last <= i == n - 1;
      pkt_valid <= 1'b1;
      if (!(c && kd == KIND_ERROR)) e.push_back({i == n - 1, rnd});
      @(posedge clk_sys_in);
      while (pkt_ready !== 1'b1) @(posedge clk_sys_in);
    end
    pkt_valid <= 1'b0;
    pkt_last <= 1'b0;
    while (txq.size() < e.size()) @(posedge clk_sys_in);
    repeat (8) @(posedge clk_sys_in);
    chk("packet length", e.size(), txq.size());
    while (e.size() > 0 && txq.size() > 0) chk("packet octet", e.pop_front(), txq.pop_front());
  endtask : send_pkt

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    // Every request kind, peer alternating prompt and slow
    for (int k = 0; k < 5; k++) begin
      rand48(hw);
      rand48(tmp);
      ip = tmp[31:0];
      if (k < 2) last_hw = hw;
      slow <= k[0];
      go_req(k[2:0]);
      chk_msg(k[2:0], ip, hw);
      chk("ack type", code(k[2:0]) + 8'h01, ack_type);
      chk("ack ip", ip, ack_ip);
      chk("ack hw", k < 3 ? last_hw : 48'h0, ack_hw);
      if (k == 2) chk("found", 1, ack_found);
      if (k == 3) chk("lcid", lcid, ack_lcid);
    end
    // Lookup miss leaves hardware address unused
    status <= 8'h01;
    go_req(3'h2);
    chk_msg(3'h2, ip, 48'h0);
    chk("miss found", 0, ack_found);
    chk("miss hw", 0, ack_hw);
    // Truncated reply is refused and the request is sent again
    status <= 8'h00;
    bad <= 1'b1;
    fork
      go_req(3'h3);
      begin
        while (errp < 1) @(posedge clk_sys_in);
        bad <= 1'b0;
      end
    join
    chk_msg(3'h3, ip, 48'h0);
    chk_msg(3'h3, ip, 48'h0);
    chk("rx errors", 1, errp);
    // Illegal request kind never taken
    req_kind <= 3'h5;
    req_valid <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk("ready on kind 5", 0, req_ready);
    req_valid <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk("tx after kind 5", 0, txq.size());
    // Five good acks, the miss reply and the resent join: one pulse each
    chk("ack pulses", 7, ackp);
    // Packets, bare and with each header kind, under stalls
    reply_en <= 1'b0;
    slow <= 1'b1;
    for (int p = 0; p < 6; p++) send_pkt(p != 0, p == 5 ? 2'h0 : 2'(p - 1), 1 + 3 * p);
    test_done();
  end
endmodule : ipv4_addr_resolution_pdu_codec_tb
`default_nettype wire
